// [src/afesp_device.sv]
// front-end serial command port: register file, command decoder, pin sharing
`default_nettype none
module afesp_device import afesp_pkg::*; (
  input wire logic i_clock, // system clock
  input wire logic i_rst_n, // power-on reset, active low
  afesp_if.dev link, // shared pins
  input wire logic i_rx_data, // demodulated receiver data
  input wire logic i_active_mode, // receive path is in active mode
  input wire logic [2:0] i_chan_active, // per-channel activity flags
  output logic [2:0] o_clamp_ch, // modulation transistor per channel
  output logic o_sleep, // low-power sleep request
  output logic o_agc_preserve, // keep captured agc level for slicing
  output logic o_agc_level_clear, // pulse: drop captured agc level
  output logic o_soft_reset, // pulse: soft reset of analog blocks
  output logic o_signal_strength_en, // strength output running
  output logic [1:0] o_output_select // receiver output format
);
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic sclk_d;
  logic cs_d;
  logic [15:0] shift_in;
  logic [3:0] bit_cnt;
  logic frame_seen;
  logic read_pending;
  logic read_phase;
  logic [3:0] read_addr;
  logic [15:0] shift_out;
  logic [8:0] cfg [0:NUM_CFG-1];
  logic alert_oe_n;
  logic sd_out;
  logic sd_oe_n;

  // two flops on everything from outside; stage one is read by stage two only
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 8'hc0;
      sync2 <= 8'hc0;
    end else begin
      sync1 <= {link.cs_line, link.sclk_line, link.sd_line, i_rx_data, i_active_mode,
                i_chan_active};
      sync2 <= sync1;
    end
  end

  wire cs_n = sync2[7];
  wire sclk = sync2[6];
  wire sdi = sync2[5];
  wire rx_data = sync2[4];
  wire active = sync2[3];
  wire [2:0] chan_active = sync2[2:0];

  // clock pin is only a clock while selected
  wire sclk_rise = !cs_n && sclk && !sclk_d;
  wire sclk_fall = !cs_n && !sclk && sclk_d;
  wire cs_fall = !cs_n && cs_d;
  wire cs_rise = cs_n && !cs_d;

  // field split of the received frame
  wire [2:0] op = shift_in[OP_MSB:OP_LSB];
  wire [3:0] addr = shift_in[ADDR_MSB:ADDR_LSB];
  wire [8:0] wdata = shift_in[REG_MSB:0];

  // a command runs at deselect only on a whole number of frames
  wire frame_ok = cs_rise && frame_seen && (bit_cnt == 4'h0) && !read_phase;
  wire do_write = frame_ok && (op == OP_WRITE) && (addr < ADDR_STATUS);
  wire do_read = frame_ok && (op == OP_READ);
  wire do_reset = frame_ok && (op == OP_SOFT_RESET) && active;

  // odd parity checks: rows, and columns of the data bytes including column parity
  // each column is gathered into a net so that it follows every register write
  logic [NUM_CFG-1:0] row_ok;
  logic [REG_MSB:1] col_good;
  for (genvar r = 0; r < NUM_CFG; r++) begin : g_row
    assign row_ok[r] = ^cfg[r];
  end
  for (genvar b = 1; b <= REG_MSB; b++) begin : g_col
    wire [NUM_CFG-1:0] col_bits;
    for (genvar r = 0; r < NUM_CFG; r++) begin : g_bit
      assign col_bits[r] = cfg[r][b];
    end
    assign col_good[b] = ^col_bits;
  end
  wire parity_err = !(&row_ok) || !(&col_good);

  // status: activity flags, parity error in bit 0 where no row parity exists
  wire [8:0] status = {chan_active, 5'h00, parity_err};
  wire [8:0] read_sel = read_addr[3] ? 9'h000 :
                        (read_addr == ADDR_STATUS) ? status : cfg[read_addr[2:0]];
  wire [2:0] chan_en = ~cfg[ADDR_GENERAL[2:0]][CH_DIS_MSB:CH_DIS_LSB];
  wire [8:0] outsel_reg = cfg[ADDR_OUTSEL[2:0]];

  // edge history for the synchronised pins
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_d <= sclk;
      cs_d <= cs_n;
    end
  end

  // receive shifter and clock counter; the counter and frame flag restart at each select, the shifter keeps its bits
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_in <= 16'h0000;
      bit_cnt <= 4'h0;
      frame_seen <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt <= 4'h0;
      frame_seen <= 1'b0;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[14:0], sdi};
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == 4'hf) begin
        frame_seen <= 1'b1;
      end
    end
  end

  // configuration registers; power-on clears them, leaving parity broken
  for (genvar r = 0; r < NUM_CFG; r++) begin : g_cfg
    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        cfg[r] <= CFG_RESET;
      end else if (do_write && addr[2:0] == 3'(r)) begin
        cfg[r] <= wdata;
      end
    end
  end

  // read bookkeeping: command frame arms, next select shifts the result out
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      read_pending <= 1'b0;
      read_phase <= 1'b0;
      read_addr <= 4'h0;
      shift_out <= 16'h0000;
    end else if (do_read) begin
      read_pending <= 1'b1;
      read_addr <= addr;
    end else if (cs_fall && read_pending) begin
      read_phase <= 1'b1;
      // gap counts as clock one, so the byte starts at the seventh clock after it
      shift_out <= {{DUMMY_BITS{1'b0}}, read_sel};
    end else if (cs_rise && read_phase) begin
      read_phase <= 1'b0;
      read_pending <= 1'b0;
    end else if (sclk_fall && read_phase) begin
      shift_out <= {shift_out[14:0], 1'b0};
    end
  end

  // command-only effects; address and data are ignored for these codes
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clamp_ch <= 3'h0;
      o_sleep <= 1'b0;
      o_agc_preserve <= 1'b0;
      o_agc_level_clear <= 1'b0;
      o_soft_reset <= 1'b0;
    end else begin
      o_soft_reset <= do_reset;
      o_agc_level_clear <= do_reset;
      if (frame_ok) begin
        o_sleep <= (op == OP_SLEEP);
        if (op == OP_CLAMP_ON) begin
          o_clamp_ch <= chan_en;
        end else if (op == OP_CLAMP_OFF) begin
          o_clamp_ch <= 3'h0;
        end
        if (op == OP_AGC_KEEP_ON) begin
          o_agc_preserve <= 1'b1;
        end else if (op == OP_AGC_KEEP_OFF) begin
          o_agc_preserve <= 1'b0;
        end
      end
    end
  end

  // pin sharing: alert pulls low only while deselected, data pin turns per phase
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alert_oe_n <= 1'b1;
      sd_out <= 1'b0;
      sd_oe_n <= 1'b0;
      o_signal_strength_en <= 1'b0;
      o_output_select <= 2'h0;
    end else begin
      alert_oe_n <= !(cs_n && parity_err);
      sd_out <= cs_n ? rx_data : shift_out[15];
      sd_oe_n <= !(cs_n || read_phase);
      o_signal_strength_en <= cs_n && outsel_reg[OUTSEL_MSB];
      o_output_select <= outsel_reg[OUTSEL_MSB:OUTSEL_LSB];
    end
  end

  assign link.dev_alert_oe_n = alert_oe_n;
  assign link.dev_sd_out = sd_out;
  assign link.dev_sd_oe_n = sd_oe_n;
endmodule : afesp_device
`default_nettype wire

// [src/afesp_pkg.sv]
// shared constants and types for the front-end serial command port
`default_nettype none
package afesp_pkg;
  // frame layout, msb first: op, address, data byte, row parity
  localparam int FRAME_BITS = 16;
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 13;
  localparam int ADDR_MSB = 12;
  localparam int ADDR_LSB = 9;
  localparam int REG_MSB = 8;
  localparam int DUMMY_BITS = 7;
  localparam int NUM_CFG = 7;
  // command codes
  localparam logic [2:0] OP_CLAMP_ON = 3'h0;
  localparam logic [2:0] OP_CLAMP_OFF = 3'h1;
  localparam logic [2:0] OP_SLEEP = 3'h2;
  localparam logic [2:0] OP_AGC_KEEP_ON = 3'h3;
  localparam logic [2:0] OP_AGC_KEEP_OFF = 3'h4;
  localparam logic [2:0] OP_SOFT_RESET = 3'h5;
  localparam logic [2:0] OP_READ = 3'h6;
  localparam logic [2:0] OP_WRITE = 3'h7;
  // register addresses and fields
  localparam logic [3:0] ADDR_GENERAL = 4'h0;
  localparam logic [3:0] ADDR_OUTSEL = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [8:0] CFG_RESET = 9'h000;
  localparam int CH_DIS_LSB = 1;
  localparam int CH_DIS_MSB = 3;
  localparam int OUTSEL_LSB = 7;
  localparam int OUTSEL_MSB = 8;
  // controller registers on the system bus
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STAT = 8'h04;
  localparam logic [7:0] HOST_RESULT = 8'h08;
  localparam int CMD_READ_BIT = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // serial clock made by the controller
  localparam int CLOCK_NS = 40;
  localparam int SCLK_PERIOD_NS = 640;
  localparam int HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLOCK_NS);
  localparam logic [3:0] HALF_CNT = 4'(HALF_CYCLES - 1);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_PARK = 3'b001,
    H_SEL = 3'b010,
    H_LOW = 3'b011,
    H_HIGH = 3'b100,
    H_END = 3'b101,
    H_DESEL = 3'b110
  } afesp_hstate_t;
endpackage : afesp_pkg
`default_nettype wire

// [src/afesp_if.sv]
// three-pin link between the front-end port and its controller
`default_nettype none
interface afesp_if;
  logic host_cs_n;
  logic host_cs_oe_n;
  logic host_sclk_out;
  logic host_sclk_oe_n;
  logic host_sd_out;
  logic host_sd_oe_n;
  logic dev_alert_oe_n;
  logic dev_sd_out;
  logic dev_sd_oe_n;
  logic cs_line;
  logic sclk_line;
  logic sd_line;
  // select has a pull-up when undriven
  assign cs_line = host_cs_oe_n ? 1'b1 : host_cs_n;
  // clock/alert line: open collector from the port, pull-up, driven by controller
  assign sclk_line = !dev_alert_oe_n ? 1'b0 : (!host_sclk_oe_n ? host_sclk_out : 1'b1);
  // data line: whichever end enables its driver
  assign sd_line = !dev_sd_oe_n ? dev_sd_out : (!host_sd_oe_n ? host_sd_out : 1'b0);
  modport dev (
    input cs_line, sclk_line, sd_line,
    output dev_alert_oe_n, dev_sd_out, dev_sd_oe_n
  );
  modport host (
    input cs_line, sclk_line, sd_line,
    output host_cs_n, host_cs_oe_n, host_sclk_out, host_sclk_oe_n, host_sd_out, host_sd_oe_n
  );
endinterface : afesp_if
`default_nettype wire

// [src/afesp_host.sv]
// controller end: ahb-lite registers drive the serial frames to the front end
`default_nettype none
module afesp_host import afesp_pkg::*; (
  input wire logic i_clock, // system clock
  input wire logic i_rst_n, // reset, active low
  afesp_if.host link, // shared pins
  input wire logic i_hsel, // slave select
  input wire logic [7:0] i_haddr, // byte address
  input wire logic [1:0] i_htrans, // transfer type
  input wire logic i_hwrite, // write when high
  input wire logic [2:0] i_hsize, // word only
  input wire logic [31:0] i_hwdata, // write data
  input wire logic i_hready, // bus ready
  output logic o_hreadyout, // always ready
  output logic o_hresp, // always okay
  output logic [31:0] o_hrdata // read data
);
  afesp_hstate_t state;
  logic [3:0] hcnt;
  logic [3:0] bcnt;
  logic [15:0] frame;
  logic [15:0] result;
  logic is_read;
  logic phase2;
  logic busy;
  logic alert_seen;
  logic [1:0] s1;
  logic [1:0] s2;
  logic ap_write;
  logic [7:0] ap_addr;
  logic cs_n;
  logic sclk_out;
  logic sclk_oe_n;
  logic sd_out;
  logic sd_oe_n;

  // address-phase decode
  wire ap_take = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
  wire start = ap_write && ap_addr == HOST_CMD && !busy;
  wire tick = hcnt == 4'h0;
  wire [31:0] rd_word = (i_haddr == HOST_CMD) ? {15'h0000, is_read, frame} :
                        (i_haddr == HOST_STAT) ? {30'h00000000, alert_seen, busy} :
                        (i_haddr == HOST_RESULT) ? {16'h0000, result} : 32'h00000000;

  // line inputs from the far end pass two flops
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
    end else begin
      s1 <= {link.sclk_line, link.sd_line};
      s2 <= s1;
    end
  end

  // bus slave: zero wait states, read data registered from the address phase
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= 32'h00000000;
    end else begin
      ap_write <= ap_take && i_hwrite;
      ap_addr <= i_haddr;
      if (ap_take && !i_hwrite) begin
        o_hrdata <= rd_word;
      end
    end
  end

  // frame sequencer; every step after idle lasts one half period of the serial clock
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= H_IDLE;
      hcnt <= HALF_CNT;
      bcnt <= 4'h0;
      frame <= 16'h0000;
      result <= 16'h0000;
      is_read <= 1'b0;
      phase2 <= 1'b0;
      busy <= 1'b0;
      alert_seen <= 1'b0;
      cs_n <= 1'b1;
      sclk_out <= 1'b0;
      sclk_oe_n <= 1'b1;
      sd_out <= 1'b0;
      sd_oe_n <= 1'b1;
    end else begin
      hcnt <= (state == H_IDLE || tick) ? HALF_CNT : hcnt - 4'h1;
      case (state)
        H_IDLE: begin
          alert_seen <= !s2[1];
          if (start) begin
            frame <= i_hwdata[15:0];
            is_read <= i_hwdata[CMD_READ_BIT];
            busy <= 1'b1;
            sclk_oe_n <= 1'b0;
            state <= H_PARK;
          end
        end
        H_PARK: if (tick) begin
          cs_n <= 1'b0;
          state <= H_SEL;
        end
        H_SEL: if (tick) begin
          bcnt <= 4'h0;
          sd_oe_n <= phase2;
          sd_out <= frame[15];
          state <= H_LOW;
        end
        H_LOW: if (tick) begin
          if (phase2) begin
            result <= {result[14:0], s2[0]};
          end
          sclk_out <= 1'b1;
          state <= H_HIGH;
        end
        H_HIGH: if (tick) begin
          sclk_out <= 1'b0;
          if (bcnt == 4'hf) begin
            sd_oe_n <= 1'b1;
            state <= H_END;
          end else begin
            bcnt <= bcnt + 4'h1;
            frame <= {frame[14:0], 1'b0};
            sd_out <= frame[14];
            state <= H_LOW;
          end
        end
        H_END: if (tick) begin
          cs_n <= 1'b1;
          state <= H_DESEL;
        end
        H_DESEL: if (tick) begin
          if (is_read && !phase2) begin
            phase2 <= 1'b1;
            state <= H_PARK;
          end else begin
            sclk_oe_n <= 1'b1;
            phase2 <= 1'b0;
            busy <= 1'b0;
            state <= H_IDLE;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  assign link.host_cs_n = cs_n;
  assign link.host_cs_oe_n = 1'b0;
  assign link.host_sclk_out = sclk_out;
  assign link.host_sclk_oe_n = sclk_oe_n;
  assign link.host_sd_out = sd_out;
  assign link.host_sd_oe_n = sd_oe_n;
endmodule : afesp_host
`default_nettype wire

// [verification/afesp_monitor.sv]
// concurrent checks on the shared pins between controller and front-end port
`default_nettype none
module afesp_monitor (
  input wire logic i_clock, // system clock
  input wire logic i_rst_n, // reset, active low
  input wire logic cs_line, // resolved select
  input wire logic sclk_line, // resolved clock/alert
  input wire logic host_sclk_out, // controller clock level
  input wire logic host_sclk_oe_n, // controller clock enable
  input wire logic host_sd_out, // controller data
  input wire logic host_sd_oe_n, // controller data enable
  input wire logic dev_alert_oe_n, // port alert pull-down
  input wire logic dev_sd_out, // port data
  input wire logic dev_sd_oe_n // port data enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] rises;
  // clock rises inside one select-low span, restarted at each select fall
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) rises <= 8'h00;
    else if ($fell(cs_line)) rises <= 8'h00;
    else if (!cs_line && $rose(sclk_line)) rises <= rises + 8'h01;
  end
  // the clock must sit parked low across both select edges
  sequence s_parked;
    !host_sclk_oe_n && !host_sclk_out;
  endsequence
  sequence s_cs_drop;
    cs_line ##1 !cs_line;
  endsequence
  sequence s_cs_lift;
    !cs_line ##1 cs_line;
  endsequence
  a_park_on_drop: assert property (s_cs_drop |-> s_parked)
    else $error("clock not parked at select fall");
  a_park_on_lift: assert property (s_cs_lift |-> s_parked)
    else $error("clock not parked at select rise");
  a_frame_whole: assert property (s_cs_lift |-> rises[3:0] == 4'h0 && rises != 8'h00)
    else $error("select span not a whole number of frames");
  a_alert_release: assert property (!cs_line [*5] |-> dev_alert_oe_n)
    else $error("alert still pulling while selected");
  a_data_desel: assert property (cs_line [*6] |-> !dev_sd_oe_n)
    else $error("data pin not driven while deselected");
  a_no_contend: assert property (!host_sd_oe_n |-> dev_sd_oe_n)
    else $error("both ends drive the data pin");
  a_dev_on_fall: assert property (!cs_line && !dev_sd_oe_n && $changed(dev_sd_out) |-> !sclk_line)
    else $error("port data changed while clock high");
  a_host_on_low: assert property (!host_sd_oe_n && $changed(host_sd_out) |-> !host_sclk_out)
    else $error("controller data changed while clock high");
  a_alert_por: assert property ($rose(i_rst_n) |-> ##[0:6] !dev_alert_oe_n)
    else $error("no alert after power-on clear");
endmodule : afesp_monitor
`default_nettype wire

// [verification/test_afe_spi_command_port.sv]
// self-checking bench: controller and front-end port joined over the shared pins
`default_nettype none
module test_afe_spi_command_port import afesp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] op; logic [3:0] a; logic [7:0] d; logic rd;
    logic [2:0] cl; logic sl; logic ag; logic [1:0] os;
  } afesp_row_t;
  logic i_clock = 1'h0;
  logic i_rst_n = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, sleep, agc, agc_clr, srst, sse;
  logic [31:0] hrdata, r;
  logic rx = 1'h0;
  logic act = 1'h1;
  logic [2:0] chan = 3'h5;
  logic [2:0] clamp, clamp2;
  logic [1:0] osel;
  logic [15:0] cap, f;
  int failures = 0, samples_checked = 0, n_srst = 0, n_clr = 0, ncap = 0;
  // expected state after each command, worked out by hand from an all-clear start
  afesp_row_t rows [9] = '{
    '{OP_WRITE, ADDR_GENERAL, 8'h02, 1'h0, 3'h0, 1'h0, 1'h0, 2'h0},
    '{OP_CLAMP_ON, 4'h3, 8'h11, 1'h0, 3'h5, 1'h0, 1'h0, 2'h0},
    '{OP_SLEEP, 4'h9, 8'h5a, 1'h0, 3'h5, 1'h1, 1'h0, 2'h0},
    '{OP_AGC_KEEP_ON, 4'hf, 8'hff, 1'h0, 3'h5, 1'h0, 1'h1, 2'h0},
    '{OP_READ, ADDR_GENERAL, 8'h02, 1'h1, 3'h5, 1'h0, 1'h1, 2'h0},
    '{OP_CLAMP_OFF, 4'h0, 8'h00, 1'h0, 3'h0, 1'h0, 1'h1, 2'h0},
    '{OP_AGC_KEEP_OFF, 4'h6, 8'h81, 1'h0, 3'h0, 1'h0, 1'h0, 2'h0},
    '{OP_WRITE, ADDR_OUTSEL, 8'h80, 1'h0, 3'h0, 1'h0, 1'h0, 2'h2},
    '{OP_READ, ADDR_OUTSEL, 8'h80, 1'h1, 3'h0, 1'h0, 1'h0, 2'h2}};
  afesp_if u_if ();
  afesp_if u_if2 ();
  afesp_host u_afesp_host (.i_clock(i_clock), .i_rst_n(i_rst_n), .link(u_if.host),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
    .o_hrdata(hrdata));
  afesp_device u_afesp_device (.i_clock(i_clock), .i_rst_n(i_rst_n), .link(u_if.dev),
    .i_rx_data(rx), .i_active_mode(act), .i_chan_active(chan), .o_clamp_ch(clamp),
    .o_sleep(sleep), .o_agc_preserve(agc), .o_agc_level_clear(agc_clr),
    .o_soft_reset(srst), .o_signal_strength_en(sse), .o_output_select(osel));
  // second port driven by the bench itself, for frames of the wrong length
  afesp_device u_afesp_device_b (.i_clock(i_clock), .i_rst_n(i_rst_n), .link(u_if2.dev),
    .i_rx_data(rx), .i_active_mode(act), .i_chan_active(chan), .o_clamp_ch(clamp2),
    .o_sleep(), .o_agc_preserve(), .o_agc_level_clear(), .o_soft_reset(),
    .o_signal_strength_en(), .o_output_select());
  afesp_monitor u_afesp_monitor (.i_clock(i_clock), .i_rst_n(i_rst_n), .cs_line(u_if.cs_line),
    .sclk_line(u_if.sclk_line), .host_sclk_out(u_if.host_sclk_out),
    .host_sclk_oe_n(u_if.host_sclk_oe_n), .host_sd_out(u_if.host_sd_out),
    .host_sd_oe_n(u_if.host_sd_oe_n), .dev_alert_oe_n(u_if.dev_alert_oe_n),
    .dev_sd_out(u_if.dev_sd_out), .dev_sd_oe_n(u_if.dev_sd_oe_n));
  initial forever #20 i_clock = ~i_clock;
  // pulse tallies, and a tap that shifts in the wire at each clock rise
  always @(posedge i_clock) begin
    if (srst === 1'h1) n_srst++;
    if (agc_clr === 1'h1) n_clr++;
  end
  always @(negedge u_if.cs_line) ncap = 0;
  always @(posedge u_if.sclk_line) if (!u_if.cs_line) begin
    cap = {cap[14:0], u_if.sd_line};
    ncap++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge i_clock); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clock); while (hready !== 1'h1);
    r = hrdata;
  endtask : bus
  // busy is polled, never assumed gone after a fixed time
  task automatic cmd(input logic [2:0] op, input logic [3:0] a, input logic [7:0] d,
      input logic rd);
    bus(1'h1, HOST_CMD, {15'h0, rd, op, a, d, ~^d});
    do bus(1'h0, HOST_STAT, 32'h0); while (r[0] !== 1'h0);
    bus(1'h0, HOST_RESULT, 32'h0);
  endtask : cmd
  // link clock from the bench: 320 ns period, four system clocks per half
  task automatic shift2(input logic [15:0] fr, input int n);
    u_if2.host_sclk_oe_n <= 1'h0;
    repeat (4) @(posedge i_clock);
    u_if2.host_cs_n <= 1'h0;
    repeat (4) @(posedge i_clock);
    u_if2.host_sd_oe_n <= 1'h0;
    for (int i = 0; i < n; i++) begin
      u_if2.host_sd_out <= fr[15 - (i % 16)];
      repeat (4) @(posedge i_clock);
      u_if2.host_sclk_out <= 1'h1;
      repeat (4) @(posedge i_clock);
      u_if2.host_sclk_out <= 1'h0;
    end
    u_if2.host_sd_oe_n <= 1'h1;
    repeat (4) @(posedge i_clock);
    u_if2.host_cs_n <= 1'h1;
    repeat (4) @(posedge i_clock);
    u_if2.host_sclk_oe_n <= 1'h1;
    repeat (10) @(posedge i_clock);
  endtask : shift2
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  initial begin
    #2000000;
    failures++;
    results();
  end
  initial begin
    {u_if2.host_cs_n, u_if2.host_cs_oe_n, u_if2.host_sclk_oe_n} <= 3'h5;
    {u_if2.host_sclk_out, u_if2.host_sd_out, u_if2.host_sd_oe_n} <= 3'h1;
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'h1;
    repeat (4) @(posedge i_clock);
    chk({clamp, sleep, agc, osel, sse}, 32'h0);
    chk(u_if.sclk_line, 32'h0);
    bus(1'h0, HOST_STAT, 32'h0);
    chk(r[1], 32'h1);
    chk(hresp, 32'h0);
    bus(1'h0, 8'h10, 32'h0);
    chk(r, 32'h0);
    cmd(OP_READ, ADDR_GENERAL, 8'h00, 1'h1);
    chk(r, 32'h0);
    for (int v = 0; v < 2; v++) begin
      rx <= v[0];
      repeat (4) @(posedge i_clock);
      chk(u_if.sd_line, 32'(v));
    end
    $display("reset test done");
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].a, rows[i].d, rows[i].rd);
      f = {rows[i].op, rows[i].a, rows[i].d, ~^rows[i].d};
      if (rows[i].rd) f = {7'h0, rows[i].d, ~^rows[i].d};
      if (rows[i].rd) chk(r, 32'(f));
      chk(cap, 32'(f));
      chk(ncap, 32'h10);
      chk({clamp, sleep, agc, osel}, {rows[i].cl, rows[i].sl, rows[i].ag, rows[i].os});
      chk(sse, 32'(rows[i].os[1]));
      $display("row %0d done", i);
    end
    // status is read-only; strength output pauses during the frame
    bus(1'h1, HOST_CMD, {15'h0, 1'h1, OP_READ, ADDR_STATUS, 9'h001});
    repeat (60) @(posedge i_clock);
    chk(sse, 32'h0);
    do bus(1'h0, HOST_STAT, 32'h0); while (r[0] !== 1'h0);
    bus(1'h0, HOST_RESULT, 32'h0);
    chk(r, 32'h141);
    cmd(OP_WRITE, ADDR_STATUS, 8'hff, 1'h0);
    cmd(OP_READ, ADDR_STATUS, 8'h00, 1'h1);
    chk(r, 32'h141);
    $display("status test done");
    cmd(OP_CLAMP_ON, 4'h0, 8'h00, 1'h0);
    cmd(OP_AGC_KEEP_ON, 4'h0, 8'h00, 1'h0);
    act <= 1'h0;
    cmd(OP_SOFT_RESET, 4'h0, 8'h00, 1'h0);
    chk(n_srst + n_clr, 32'h0);
    act <= 1'h1;
    cmd(OP_SOFT_RESET, 4'h0, 8'h00, 1'h0);
    chk({n_srst[3:0], n_clr[3:0], clamp, agc}, {8'h11, 3'h5, 1'h1});
    $display("soft reset test done");
    // power-on clear again in mid-run: every setting drops and the alert returns
    i_rst_n <= 1'h0;
    repeat (4) @(posedge i_clock);
    chk({clamp, sleep, agc, osel, sse}, 32'h0);
    i_rst_n <= 1'h1;
    repeat (4) @(posedge i_clock);
    chk(u_if.sclk_line, 32'h0);
    cmd(OP_READ, ADDR_OUTSEL, 8'h00, 1'h1);
    chk(r, 32'h0);
    $display("mid-run reset test done");
    shift2({OP_CLAMP_ON, 13'h0}, 15);
    chk(clamp2, 32'h0);
    shift2({OP_CLAMP_ON, 13'h0}, 17);
    chk(clamp2, 32'h0);
    shift2({OP_CLAMP_ON, 13'h1fff}, 32);
    chk(clamp2, 32'h7);
    $display("frame length test done");
    results();
  end
endmodule : test_afe_spi_command_port
`default_nettype wire
